// File: acs_sequencer.v
// Conversion sequencer top: registers, start/complete/abort, sleep and trigger
// Summary of operation
// - Channel select field routes one analog input to the sample-and-hold.
// - Positive reference supply or external; negative ground or external, independently.
// - Clock select: div 2, div 8, div 32, or RC for codes x11.
// - Full conversion takes eleven bit periods, one decision in each of the last ten.
// - Divided clock follows system clock; RC source is independent.
// - Completion flag set on every conversion regardless of interrupt enable.
// - Enabled completion interrupt wakes a sleeping device.
// - Result presented left or right justified by format bit.
// - Converter works only when enabled; writing go starts conversion.
// - At completion: clear go, set flag, load result registers.
// - Clearing go mid-conversion aborts and keeps previous result.
// - After abort wait two bit periods, then acquisition restarts.
// - Reset returns registers to reset values and stops conversion.
// - With RC source, start delayed four extra bit periods.
// - Sleep with RC and interrupt off: converter off after completion.
// - Sleep with non-RC clock aborts conversion; converter stays off only while interrupt disabled.
// - Hardware trigger sets go and resets the trigger timer.
// - Codes 0-13 analog inputs, 14 comparator reference, 15 fixed reference.
// - Format 1 right justified; 0 left justified with top eight high.
// - Reference bits: 1 selects external pins, 0 supply or ground.
`timescale 1ns/10ps
`include "acs_defs.vh"
module acs_sequencer #(
   parameter WIDTH = 10                // Result width
) (
   input  wire             ref_clk,    // System clock, 25 MHz
   input  wire             rst_n,      // Async reset, active low
   input  wire             clk_en,     // Freezes all state while low
   input  wire [2:0]       reg_addr,   // Register index
   input  wire [7:0]       reg_wdata,  // Write data
   input  wire             reg_wr,     // Write strobe
   input  wire             reg_rd,     // Read strobe
   output reg  [7:0]       reg_rdata,  // Read data, cycle after strobe
   input  wire             rc_osc,     // Internal RC oscillator, async
   input  wire             sleep_req,  // Core is asleep, async level
   input  wire             evt_trig,   // Special event trigger pulse
   input  wire             cmp_hi,     // Comparator result, async
   output reg  [3:0]       chan_sel,   // Analog mux select
   output reg              ref_pos_ext,// Positive reference external
   output reg              ref_neg_ext,// Negative reference external
   output wire [WIDTH-1:0] dac_code,   // Trial code to the DAC
   output reg              sample_en,  // Sample-and-hold tracking
   output reg              analog_on,  // Converter powered
   output reg              timer_clr,  // Trigger timer reset pulse
   output reg              wake_req,   // Wake request to the core
   output wire             conv_done_flag // Completion flag
);
   // =====================================================================
   // State
   // =====================================================================
   localparam ST_IDLE  = 4'b0001;
   localparam ST_DELAY = 4'b0010;
   localparam ST_CONV  = 4'b0100;
   localparam ST_ABORT = 4'b1000;
   reg  [3:0]       state;
   reg  [3:0]       period_cnt;
   reg  [2:0]       conv_clk_sel;
   reg              conv_enable;
   reg              go;
   reg              result_format_sel;
   reg              done_flag;
   reg              conv_done_irq_en;
   reg  [WIDTH-1:0] result;
   reg              powered_down;
   reg  [2:0]       sleep_sync;
   reg              sleep_now;
   reg              div_restart;
   wire             bit_tick;
   wire [WIDTH-1:0] sar_mask;
   wire             rc_mode;
   wire             sar_load;
   wire             sar_step;
   wire             sw_go_set;
   wire             sw_go_clr;
   wire             finish;
   wire             sleep_abort;
   wire [7:0]       ctrl0_rd;
   wire [7:0]       res_high;
   wire [7:0]       res_low;
   assign rc_mode   = (conv_clk_sel[1:0] == 2'b11);
   assign sw_go_set = reg_wr && reg_addr == `ACS_ADDR_CTRL0 && reg_wdata[`ACS_C0_GO];
   assign sw_go_clr = reg_wr && reg_addr == `ACS_ADDR_CTRL0 && !reg_wdata[`ACS_C0_GO];
   assign finish    = (state == ST_CONV) && bit_tick && period_cnt == `ACS_CONV_PERIODS - 4'h1;
   // Non-RC clock cannot run in sleep, so the conversion is lost
   assign sleep_abort = sleep_now && !rc_mode && (state == ST_DELAY || state == ST_CONV);
   assign sar_load  = (state == ST_DELAY) && bit_tick && period_cnt == 4'h0;
   assign sar_step  = (state == ST_CONV) && bit_tick && period_cnt != 4'h0;
   assign conv_done_flag = done_flag;
   // =====================================================================
   // Submodules
   // =====================================================================
   acs_clk_gen u_clk (
      .ref_clk      (ref_clk),
      .rst_n        (rst_n),
      .clk_en       (clk_en),
      .conv_clk_sel (conv_clk_sel),
      .rc_osc       (rc_osc),
      .run          (state != ST_IDLE && !div_restart),
      .bit_tick     (bit_tick)
   );
   acs_sar #(.WIDTH(WIDTH)) u_sar (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .clk_en  (clk_en),
      .load    (sar_load),
      .step    (sar_step),
      .cmp_hi  (cmp_hi),
      .trial   (dac_code),
      .mask    (sar_mask)
   );
   // =====================================================================
   // Input synchronisers
   // =====================================================================
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         sleep_sync <= 3'h0;
         sleep_now  <= 1'b0;
      end else if (clk_en) begin
         sleep_sync <= {sleep_sync[1:0], sleep_req};
         if (sleep_sync[1] == sleep_sync[2]) begin
            sleep_now <= sleep_sync[2];
         end
      end
   end
   // =====================================================================
   // Registers and sequencer
   // =====================================================================
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state             <= ST_IDLE;
         period_cnt        <= 4'h0;
         conv_clk_sel      <= 3'h0;
         chan_sel          <= 4'h0;
         conv_enable       <= 1'b0;
         go                <= 1'b0;
         result_format_sel <= 1'b0;
         ref_pos_ext       <= 1'b0;
         ref_neg_ext       <= 1'b0;
         done_flag         <= 1'b0;
         conv_done_irq_en  <= 1'b0;
         result            <= `ACS_RESULT_RESET;
         powered_down      <= 1'b0;
         timer_clr         <= 1'b0;
         wake_req          <= 1'b0;
         div_restart       <= 1'b0;
      end else if (clk_en) begin
         timer_clr <= 1'b0;
         wake_req  <= 1'b0;
         div_restart <= 1'b0;
         if (reg_wr && reg_addr == `ACS_ADDR_CTRL0) begin
            conv_clk_sel <= {1'b0, reg_wdata[`ACS_C0_CLK_LSB+1:`ACS_C0_CLK_LSB]};
            chan_sel     <= reg_wdata[`ACS_C0_CHAN_LSB+3:`ACS_C0_CHAN_LSB];
            conv_enable  <= reg_wdata[`ACS_C0_ENABLE];
         end
         if (reg_wr && reg_addr == `ACS_ADDR_CTRL1) begin
            result_format_sel <= reg_wdata[`ACS_C1_FORMAT];
            ref_pos_ext       <= reg_wdata[`ACS_C1_REF_POS];
            ref_neg_ext       <= reg_wdata[`ACS_C1_REF_NEG];
         end
         if (reg_wr && reg_addr == `ACS_ADDR_IRQ_EN) begin
            conv_done_irq_en <= reg_wdata[0];
         end
         // Completion sets the flag even in the cycle software clears it
         if (finish) begin
            done_flag <= 1'b1;
         end else if (reg_wr && reg_addr == `ACS_ADDR_FLAGS && !reg_wdata[0]) begin
            done_flag <= 1'b0;
         end
         if (!sleep_now || conv_done_irq_en) begin
            powered_down <= 1'b0;
         end
         case (state)
            ST_IDLE: begin
               period_cnt <= 4'h0;
               if ((sw_go_set || evt_trig) && conv_enable) begin
                  go         <= 1'b1;
                  timer_clr  <= evt_trig;
                  state      <= ST_DELAY;
                  period_cnt <= rc_mode ? `ACS_RC_START_DELAY : 4'h0;
               end else if (sw_go_clr) begin
                  go <= 1'b0;
               end
            end
            ST_DELAY: begin
               if (sw_go_clr || !conv_enable || sleep_abort) begin
                  go         <= 1'b0;
                  state      <= ST_ABORT;
                  period_cnt <= 4'h0;
                  powered_down <= sleep_abort;
                  div_restart <= 1'b1;
               end else if (bit_tick) begin
                  if (period_cnt == 4'h0) begin
                     state <= ST_CONV;
                  end else begin
                     period_cnt <= period_cnt - 4'h1;
                  end
               end
            end
            ST_CONV: begin
               if (sw_go_clr || !conv_enable || sleep_abort) begin
                  go           <= 1'b0;
                  state        <= ST_ABORT;
                  period_cnt   <= 4'h0;
                  powered_down <= sleep_abort;
                  div_restart  <= 1'b1;
               end else if (finish) begin
                  go     <= 1'b0;
                  state  <= ST_IDLE;
                  // Comparator settles on our own trial code, so it is taken like same-clock logic
                  result <= (dac_code & ~sar_mask) | (cmp_hi ? sar_mask : {WIDTH{1'b0}});
                  wake_req <= sleep_now && conv_done_irq_en;
                  powered_down <= sleep_now && rc_mode && !conv_done_irq_en;
               end else if (bit_tick) begin
                  period_cnt <= period_cnt + 4'h1;
               end
            end
            ST_ABORT: begin
               // Divider restarted on entry, so with a divided clock both waits are whole periods
               if (bit_tick && !div_restart) begin
                  if (period_cnt == `ACS_ABORT_PERIODS - 4'h1) begin
                     state <= ST_IDLE;
                  end else begin
                     period_cnt <= period_cnt + 4'h1;
                  end
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end
   // =====================================================================
   // Analog control and result formatting
   // =====================================================================
   always @* begin
      analog_on = conv_enable && !powered_down;
      sample_en = analog_on && state == ST_IDLE;
   end
   assign res_high = result_format_sel ? {6'h00, result[9:8]} : result[9:2];
   assign res_low  = result_format_sel ? result[7:0] : {result[1:0], 6'h00};
   assign ctrl0_rd = {conv_clk_sel[1:0], chan_sel, go, conv_enable};
   // =====================================================================
   // Read port
   // =====================================================================
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
      end else if (clk_en) begin
         if (!reg_rd) begin
            reg_rdata <= 8'h00;
         end else if (reg_addr == `ACS_ADDR_CTRL0) begin
            reg_rdata <= ctrl0_rd;
         end else if (reg_addr == `ACS_ADDR_CTRL1) begin
            reg_rdata <= {result_format_sel, 1'b0, ref_neg_ext, ref_pos_ext, 4'h0};
         end else if (reg_addr == `ACS_ADDR_RES_HIGH) begin
            reg_rdata <= res_high;
         end else if (reg_addr == `ACS_ADDR_RES_LOW) begin
            reg_rdata <= res_low;
         end else if (reg_addr == `ACS_ADDR_FLAGS) begin
            reg_rdata <= {7'h00, done_flag};
         end else if (reg_addr == `ACS_ADDR_IRQ_EN) begin
            reg_rdata <= {7'h00, conv_done_irq_en};
         end else begin
            reg_rdata <= 8'h00;
         end
      end
   end
endmodule

// File: acs_defs.vh
// Register offsets, field positions, reset values and timing counts for the conversion sequencer
`ifndef ACS_DEFS_VH
`define ACS_DEFS_VH
// Register indices on the plain register port
`define ACS_ADDR_CTRL0      3'h0
`define ACS_ADDR_CTRL1      3'h1
`define ACS_ADDR_RES_HIGH   3'h2
`define ACS_ADDR_RES_LOW    3'h3
`define ACS_ADDR_FLAGS      3'h4
`define ACS_ADDR_IRQ_EN     3'h5
// conv_ctrl0 fields
`define ACS_C0_ENABLE       0
`define ACS_C0_GO           1
`define ACS_C0_CHAN_LSB     2
`define ACS_C0_CLK_LSB      6
// conv_ctrl1 fields
`define ACS_C1_REF_POS      4
`define ACS_C1_REF_NEG      5
`define ACS_C1_FORMAT       7
// Reset values
`define ACS_CTRL0_RESET     8'h00
`define ACS_CTRL1_RESET     8'h00
`define ACS_RESULT_RESET    10'h000
// Clock select codes
`define ACS_CLK_DIV2        3'h0
`define ACS_CLK_DIV8        3'h1
`define ACS_CLK_DIV32       3'h2
// Timing counts in bit periods
`define ACS_CONV_PERIODS    4'hB
`define ACS_ABORT_PERIODS   4'h2
`define ACS_RC_START_DELAY  4'h4
// Channel codes with special meaning
`define ACS_CHAN_CMP_REF    4'hE
`define ACS_CHAN_FIXED_REF  4'hF
`endif

// File: acs_clk_gen.v
// Bit-period tick generator: divided system clock or internal RC tick
`timescale 1ns/10ps
`include "acs_defs.vh"
module acs_clk_gen (
   input  wire       ref_clk,      // System clock
   input  wire       rst_n,        // Async reset, active low
   input  wire       clk_en,       // Clock enable
   input  wire [2:0] conv_clk_sel, // Conversion clock select
   input  wire       rc_osc,       // Internal RC oscillator, async
   input  wire       run,          // Restarts divider while low
   output reg        bit_tick      // One pulse per bit period
);
   reg  [4:0] div_cnt;
   reg  [2:0] rc_sync;
   reg        rc_seen;
   wire       rc_mode;
   reg  [4:0] div_top;
   assign rc_mode = (conv_clk_sel[1:0] == 2'b11);
   always @* begin
      if (conv_clk_sel == `ACS_CLK_DIV2) begin
         div_top = 5'h01;
      end else if (conv_clk_sel == `ACS_CLK_DIV8) begin
         div_top = 5'h07;
      end else begin
         div_top = 5'h1F;
      end
   end
   // RC tick: one per rising edge seen once stages 2 and 3 agree
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         div_cnt  <= 5'h00;
         rc_sync  <= 3'h0;
         rc_seen  <= 1'b0;
         bit_tick <= 1'b0;
      end else if (clk_en) begin
         rc_sync <= {rc_sync[1:0], rc_osc};
         if (rc_sync[1] == rc_sync[2]) begin
            rc_seen <= rc_sync[2];
         end
         if (rc_mode) begin
            div_cnt  <= 5'h00;
            bit_tick <= run && (rc_sync[1] == rc_sync[2]) && rc_sync[2] && !rc_seen;
         end else if (!run || div_cnt == div_top) begin
            div_cnt  <= 5'h00;
            bit_tick <= run;
         end else begin
            div_cnt  <= div_cnt + 5'h01;
            bit_tick <= 1'b0;
         end
      end
   end
endmodule

// File: acs_sar.v
// Successive approximation register: one bit decision per bit period
`timescale 1ns/10ps
module acs_sar #(
   parameter WIDTH = 10            // Result width
) (
   input  wire             ref_clk, // System clock
   input  wire             rst_n,   // Async reset, active low
   input  wire             clk_en,  // Clock enable
   input  wire             load,    // Start a new approximation
   input  wire             step,    // Make one bit decision
   input  wire             cmp_hi,  // Comparator: input above trial
   output reg  [WIDTH-1:0] trial,   // Trial code to the DAC
   output reg  [WIDTH-1:0] mask     // Bit being decided
);
   wire [WIDTH-1:0] mask_up;       // Mask of the next lower bit
   assign mask_up = {1'b0, mask[WIDTH-1:1]};
   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
         always @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
               trial[i] <= 1'b0;
               mask[i]  <= 1'b0;
            end else if (clk_en) begin
               if (load) begin
                  trial[i] <= (i == WIDTH-1);
                  mask[i]  <= (i == WIDTH-1);
               end else if (step) begin
                  if (mask[i]) begin
                     trial[i] <= cmp_hi;
                  end
                  if (mask_up[i]) begin
                     trial[i] <= 1'b1;
                  end
                  mask[i] <= mask_up[i];
               end
            end
         end
      end
   endgenerate
endmodule

// File: acs_analog_model.sv
// Analog far side: ideal input levels, comparator and RC oscillator
`timescale 1ns/10ps
module acs_analog_model #(
   parameter RC_HALF = 2000 // Half RC period in ns, 4 us typical
) (
   input  wire [3:0] chan_sel, // Selected input
   input  wire [9:0] dac_code, // Trial code
   output wire       cmp_hi,   // Input above trial
   output reg        rc_osc    // Free-running RC clock
);
   logic [9:0] lvl [0:15];
   // Levels sit half a step above their code, so no tie with a trial
   assign cmp_hi = {lvl[chan_sel], 1'b1} > {dac_code, 1'b0};
   initial begin
      foreach (lvl[i]) lvl[i] = 10'h000;
      rc_osc = 1'b0;
      #7;
      // Own timebase, unrelated to the system clock
      forever #(RC_HALF) rc_osc = ~rc_osc;
   end
endmodule

// File: acs_sequencer_assertions.sv
// Port-level checks for the conversion sequencer
`timescale 1ns/10ps
module acs_sequencer_checker (
   input wire       ref_clk,       // Clock
   input wire       rst_n,         // Reset
   input wire [2:0] reg_addr,      // Index
   input wire [7:0] reg_wdata,     // Write data
   input wire       reg_wr,        // Write strobe
   input wire       evt_trig,      // Trigger
   input wire [3:0] chan_sel,      // Mux select
   input wire       ref_pos_ext,   // Pos reference
   input wire       ref_neg_ext,   // Neg reference
   input wire       sample_en,     // Tracking
   input wire       analog_on,     // Powered
   input wire       timer_clr,     // Timer reset
   input wire       wake_req,      // Wake
   input wire       conv_done_flag // Done flag
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // ====
   // Register-driven outputs
   chk_chan_follows: assert property ($past(reg_wr) && $past(reg_addr) == 3'h0 |->
      chan_sel == $past(reg_wdata[5:2])) else $error("channel select differs from write");
   chk_chan_stable: assert property ($changed(chan_sel) |->
      $past(reg_wr) && $past(reg_addr) == 3'h0) else $error("channel select moved alone");
   chk_ref_follows: assert property ($past(reg_wr) && $past(reg_addr) == 3'h1 |->
      ref_pos_ext == $past(reg_wdata[4]) && ref_neg_ext == $past(reg_wdata[5]))
      else $error("reference selects differ from write");
   chk_ref_stable: assert property ($changed({ref_pos_ext, ref_neg_ext}) |->
      $past(reg_wr) && $past(reg_addr) == 3'h1) else $error("reference select moved alone");
   // ====
   // Events
   chk_clr_cause: assert property (timer_clr |-> $past(evt_trig) || $past(evt_trig, 2))
      else $error("timer clear without trigger");
   chk_clr_pulse: assert property (timer_clr |=> !timer_clr)
      else $error("timer clear longer than one cycle");
   chk_flag_sticky: assert property (conv_done_flag && !(reg_wr && reg_addr == 3'h4 && !reg_wdata[0])
      |=> conv_done_flag) else $error("done flag dropped by itself");
   chk_flag_cause: assert property ($rose(conv_done_flag) |-> !$past(sample_en))
      else $error("done flag rose while idle");
   chk_track_power: assert property (sample_en |-> analog_on && !timer_clr)
      else $error("tracking while powered off or converting");
   chk_track_after: assert property ($rose(conv_done_flag) |-> sample_en || !analog_on)
      else $error("no tracking after completion");
   chk_wake_flag: assert property (wake_req |-> ##[0:1] conv_done_flag)
      else $error("wake without completion");
endmodule
bind acs_sequencer acs_sequencer_checker acs_sequencer_checker_inst (.ref_clk(ref_clk), .rst_n(rst_n),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .evt_trig(evt_trig), .chan_sel(chan_sel),
   .ref_pos_ext(ref_pos_ext), .ref_neg_ext(ref_neg_ext), .sample_en(sample_en), .analog_on(analog_on),
   .timer_clr(timer_clr), .wake_req(wake_req), .conv_done_flag(conv_done_flag));

// File: test_acs_sequencer.sv
// Self-checking testbench for the conversion sequencer
`timescale 1ns/10ps
module test_acs_sequencer;
   logic       ref_clk = 1'b0;
   logic       rst_n = 1'b0;
   logic [2:0] reg_addr = 3'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic       reg_wr = 1'b0;
   logic       reg_rd = 1'b0;
   logic       sleep_req = 1'b0;
   logic       evt_trig = 1'b0;
   logic       clk_en = 1'b1;
   wire  [7:0] reg_rdata;
   wire  [3:0] chan_sel;
   wire  [9:0] dac_code;
   wire        cmp_hi, rc_osc, ref_pos_ext, ref_neg_ext;
   wire        sample_en, analog_on, timer_clr, wake_req, conv_done_flag;
   int         n_mismatch = 0;
   int         n_tests = 0;
   int         n_wake = 0;
   int         n_clr = 0;
   int         n, e;
   logic [9:0] last;
   logic [7:0] d;

   acs_sequencer acs_sequencer_inst (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rc_osc(rc_osc),
      .sleep_req(sleep_req), .evt_trig(evt_trig), .cmp_hi(cmp_hi), .chan_sel(chan_sel),
      .ref_pos_ext(ref_pos_ext), .ref_neg_ext(ref_neg_ext), .dac_code(dac_code), .sample_en(sample_en),
      .analog_on(analog_on), .timer_clr(timer_clr), .wake_req(wake_req), .conv_done_flag(conv_done_flag));
   acs_analog_model acs_analog_model_inst (.chan_sel(chan_sel), .dac_code(dac_code), .cmp_hi(cmp_hi),
      .rc_osc(rc_osc));

   initial begin
      forever #20 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      n_wake <= n_wake + (wake_req === 1'b1);
      n_clr <= n_clr + (timer_clr === 1'b1);
   end

   // ====
   // Bus and comparison helpers
   task automatic wr(input logic [2:0] a, input logic [7:0] v);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] a, output logic [7:0] v);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      @(posedge ref_clk);
      v = reg_rdata;
   endtask
   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   // ====
   // One conversion, by write or by trigger, then both result formats
   task automatic conv(input logic [3:0] ch, input logic [1:0] ck, input logic [9:0] v, input bit trig);
      realtime t0;
      int per, k, c0;
      logic [7:0] r, hi, lo;
      per = (ck == 2'h3) ? 4000 : (80 << (2 * ck));
      acs_analog_model_inst.lvl[ch] = v;
      wr(3'h0, {ck, ch, 2'b01});
      repeat (120) @(posedge ref_clk);
      chk("tracking", 1, sample_en);
      chk("chan_sel", ch, chan_sel);
      t0 = $realtime;
      c0 = n_clr;
      if (trig) begin
         @(posedge ref_clk);
         evt_trig <= 1'b1;
         @(posedge ref_clk);
         evt_trig <= 1'b0;
         repeat (3) @(posedge ref_clk);
         chk("timer clear", c0 + 1, n_clr);
      end else begin
         wr(3'h0, {ck, ch, 2'b11});
      end
      rd(3'h0, r);
      chk("go busy", 1, r[1]);
      k = 0;
      while (r[1] !== 1'b0 && k < 3000) begin
         rd(3'h0, r);
         k++;
      end
      chk("time low", 1, $realtime - t0 >= ((ck == 2'h3) ? 12 : 11) * per);
      chk("time high", 1, $realtime - t0 <= 20 * per + 400);
      rd(3'h4, r);
      chk("done flag", 1, r[0]);
      wr(3'h4, 8'h01);
      rd(3'h4, r);
      chk("flag kept", 1, r[0]);
      wr(3'h1, 8'h80);
      rd(3'h2, hi);
      rd(3'h3, lo);
      chk("right", v, {hi[1:0], lo});
      wr(3'h1, 8'h00);
      rd(3'h2, hi);
      rd(3'h3, lo);
      chk("left", v, {hi, lo[7:6]});
      wr(3'h4, 8'h00);
      last = v;
   endtask

   initial begin
      #3000000;
      n_mismatch++;
      wrap_up;
   end

   initial begin
      void'($urandom(32'h890C1E0A));
      repeat (3) @(posedge ref_clk);
      rst_n <= 1'b1;
      for (n = 0; n < 8; n++) begin
         rd(n[2:0], d);
         chk("reset reg", 0, d);
      end
      $display("test reset values done");
      // Clock enable low must swallow a write
      clk_en <= 1'b0;
      wr(3'h5, 8'h01);
      clk_en <= 1'b1;
      rd(3'h5, d);
      chk("frozen", 0, d);
      wr(3'h0, 8'h02);
      rd(3'h0, d);
      chk("go while off", 0, d);
      for (n = 0; n < 4; n++) begin
         wr(3'h1, {2'b00, n[1:0], 4'h0});
         @(posedge ref_clk);
         chk("ref pos", n[0], ref_pos_ext);
         chk("ref neg", n[1], ref_neg_ext);
      end
      $display("test go and references done");
      for (n = 0; n < 4; n++) conv(4'($urandom % 14), n[1:0], 10'($urandom), 1'b0);
      conv(4'hE, 2'h0, 10'($urandom), 1'b1);
      conv(4'hF, 2'h1, 10'($urandom), 1'b0);
      $display("test conversions done");
      // Abort in mid-conversion keeps the old result
      wr(3'h0, 8'h89);
      repeat (120) @(posedge ref_clk);
      wr(3'h0, 8'h8B);
      repeat (40) @(posedge ref_clk);
      wr(3'h0, 8'h89);
      n = 0;
      while (sample_en !== 1'b1 && n < 200) begin
         @(posedge ref_clk);
         n++;
      end
      chk("abort gap", 1, n >= 64 && n <= 68);
      rd(3'h0, d);
      chk("go aborted", 8'h89, d);
      rd(3'h2, d);
      chk("kept result", last[9:2], d);
      rd(3'h4, d);
      chk("no flag", 0, d[0]);
      $display("test abort done");
      // Sleep with a divided clock aborts and powers down
      wr(3'h0, 8'h8B);
      repeat (40) @(posedge ref_clk);
      sleep_req <= 1'b1;
      n = 0;
      while (analog_on !== 1'b0 && n < 40) begin
         @(posedge ref_clk);
         n++;
      end
      chk("off in sleep", 0, analog_on);
      rd(3'h0, d);
      chk("enable kept", 8'h89, d);
      sleep_req <= 1'b0;
      // Let the two-period abort wait run out before the next start
      repeat (80) @(posedge ref_clk);
      // Sleep with the RC clock, interrupt on then off
      for (e = 1; e >= 0; e--) begin
         wr(3'h5, e[7:0]);
         wr(3'h0, 8'hC1);
         repeat (120) @(posedge ref_clk);
         n = n_wake;
         wr(3'h0, 8'hC3);
         sleep_req <= 1'b1;
         repeat (3000) begin
            if (conv_done_flag !== 1'b1) @(posedge ref_clk);
         end
         repeat (8) @(posedge ref_clk);
         chk("wake", n + e, n_wake);
         chk("power", e, analog_on);
         rd(3'h0, d);
         chk("enable held", 8'hC1, d);
         sleep_req <= 1'b0;
         wr(3'h4, 8'h00);
         repeat (20) @(posedge ref_clk);
      end
      $display("test sleep done");
      // Reset in mid-conversion
      wr(3'h0, 8'h8B);
      repeat (40) @(posedge ref_clk);
      rst_n <= 1'b0;
      repeat (3) @(posedge ref_clk);
      rst_n <= 1'b1;
      rd(3'h0, d);
      chk("ctrl after reset", 0, d);
      rd(3'h2, d);
      chk("result after reset", 0, d);
      $display("test reset in conversion done");
      wrap_up;
   end
endmodule
